// >>> aes_pkg.sv
// package: constants for the alarm and error-signalling block
package aes_pkg;
   // system clock and blink timing
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned FAST_BLINK_HZ = 4;
   localparam int unsigned SLOW_BLINK_HZ = 1;
   // half period counts, one shared base tick at the fast half period
   localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_BLINK_HZ);
   localparam int unsigned SLOW_DIV      = FAST_BLINK_HZ / SLOW_BLINK_HZ;

   // error level output: millivolt code on a 0..10000 scale, 14 bits
   localparam int unsigned LVL_W = 14;
   localparam logic [13:0] LVL_FULL  = 14'h2710; // 10.00 V
   localparam logic [13:0] LVL_0V66  = 14'h0294; // 0.66 V
   localparam logic [13:0] LVL_1V33  = 14'h0535; // 1.33 V
   localparam logic [13:0] LVL_2V00  = 14'h07D0; // 2.00 V
   localparam logic [13:0] LVL_2V66  = 14'h0A64; // 2.66 V
   localparam logic [13:0] LVL_3V33  = 14'h0D05; // 3.33 V
   localparam logic [13:0] LVL_4V00  = 14'h0FA0; // 4.00 V
   localparam logic [13:0] LVL_4V66  = 14'h1234; // 4.66 V
   localparam logic [13:0] LVL_5V33  = 14'h14D5; // 5.33 V
   localparam logic [13:0] LVL_6V00  = 14'h1770; // 6.00 V
   localparam logic [13:0] LVL_6V66  = 14'h1A04; // 6.66 V
   localparam logic [13:0] LVL_7V33  = 14'h1CA5; // 7.33 V
   localparam logic [13:0] LVL_8V00  = 14'h1F40; // 8.00 V
   localparam logic [13:0] LVL_8V66  = 14'h21D4; // 8.66 V

   // error group bit positions on the error input vector
   localparam int unsigned GRP_N          = 13;
   localparam int unsigned G_NO_CURRENT   = 0;  // 101
   localparam int unsigned G_NO_VOLTAGE   = 1;  // 102
   localparam int unsigned G_NO_BOTH      = 2;  // 103
   localparam int unsigned G_TEMP_JUMP    = 3;  // 107,108,307..310
   localparam int unsigned G_NET_FREQ     = 4;  // 201..203
   localparam int unsigned G_HEAT_TIME    = 5;  // 304
   localparam int unsigned G_INTERNAL     = 6;  // 9xx
   localparam int unsigned G_ZERO_SIGNAL  = 7;  // 104..106
   localparam int unsigned G_ZERO_TEMP    = 8;  // 211,302,303
   localparam int unsigned G_CFG_CURRENT  = 9;  // 111
   localparam int unsigned G_CFG_VOLTAGE  = 10; // 112
   localparam int unsigned G_CFG_BOTH     = 11; // 113,114
   localparam int unsigned G_CFG_EXT      = 12; // 115,116

   // alarm class, one-hot
   typedef enum logic [3:0] {
      AES_CLS_NONE  = 4'h1,
      AES_CLS_ZERO  = 4'h2,
      AES_CLS_CFG   = 4'h4,
      AES_CLS_FAULT = 4'h8
   } aes_class_t;
endpackage

// >>> aes_blink_div.sv
// module: shared blink divider giving 4 Hz and 1 Hz phases
`timescale 1ns/1ps
module aes_blink_div
   import aes_pkg::*;
#(
   parameter int unsigned HALF_CYC = FAST_HALF_CYC
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic ce,
   output logic      fast_ph,
   output logic      slow_ph
);
   logic [31:0] cnt_r;
   logic [1:0]  sub_r;

   // one counter is the single phase reference for both rates
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r   <= 32'h0;
         sub_r   <= 2'h0;
         fast_ph <= 1'b0;
         slow_ph <= 1'b0;
      end else if (ce) begin
         if (cnt_r == HALF_CYC - 1) begin
            cnt_r   <= 32'h0;
            fast_ph <= ~fast_ph;
            sub_r   <= 2'(sub_r + 2'h1);
            // slow phase toggles once per SLOW_DIV fast toggles, so 4 Hz becomes 1 Hz
            if (sub_r == 2'(SLOW_DIV - 1)) begin
               slow_ph <= ~slow_ph;
            end
         end else begin
            cnt_r <= 32'(cnt_r + 32'h1);
         end
      end
   end
endmodule // aes_blink_div

// >>> aes_alarm.sv
// module: alarm classification, LED, alarm output and error level output
`timescale 1ns/1ps
module aes_alarm
   import aes_pkg::*;
#(
   parameter int unsigned HALF_CYC = FAST_HALF_CYC
) (
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic                ce,
   input  wire logic [GRP_N-1:0]    err_in,
   input  wire logic                start_in,
   input  wire logic                reset_in,
   input  wire logic                alarm_pol_inv,
   input  wire logic [LVL_W-1:0]    temp_level,
   output logic                     alarm_led,
   output logic                     alarm_out,
   output logic [LVL_W-1:0]         actual_out,
   output logic                     alarm_active
);
   logic [GRP_N-1:0] err_s1_r, err_s2_r, err_r;
   logic [2:0]       start_s_r, reset_s_r;
   logic             latched_start_r;
   logic             fast_ph, slow_ph;
   logic             rst_fall;
   aes_class_t       cls;
   logic [LVL_W-1:0] lvl;

   aes_blink_div #(.HALF_CYC(HALF_CYC)) u_div (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .fast_ph (fast_ph),
      .slow_ph (slow_ph)
   );

   // pin inputs pass two flops; third stage only for edge detection
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         err_s1_r  <= '0;
         err_s2_r  <= '0;
         start_s_r <= 3'h0;
         reset_s_r <= 3'h0;
      end else if (ce) begin
         err_s1_r  <= err_in;
         err_s2_r  <= err_s1_r;
         start_s_r <= {start_s_r[1:0], start_in};
         reset_s_r <= {reset_s_r[1:0], reset_in};
      end
   end

   assign rst_fall = reset_s_r[2] & ~reset_s_r[1]; // release of reset input

   // errors latch until cleared; a new report wins over a clear
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         err_r <= '0; // power cycle clears everything
      end else if (ce) begin
         if (rst_fall) begin
            err_r <= err_s2_r; // clear only on release, not while held
         end else if (!reset_s_r[1]) begin
            err_r <= err_r | err_s2_r;
         end
      end
   end

   // classify: malfunctions dominate, then zeroing, then configuration
   always_comb begin
      if (|err_r[G_INTERNAL:G_NO_CURRENT]) begin
         cls = AES_CLS_FAULT;
      end else if (err_r[G_ZERO_SIGNAL] | err_r[G_ZERO_TEMP]) begin
         cls = AES_CLS_ZERO;
      end else if (|err_r[G_CFG_EXT:G_CFG_CURRENT]) begin
         cls = AES_CLS_CFG;
      end else begin
         cls = AES_CLS_NONE;
      end
   end

   // start seen during a warning turns it into a malfunction until cleared
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         latched_start_r <= 1'b0;
      end else if (ce) begin
         if (cls == AES_CLS_ZERO || cls == AES_CLS_CFG) begin
            if (start_s_r[1]) begin
               latched_start_r <= 1'b1;
            end
         end else begin
            latched_start_r <= 1'b0;
         end
      end
   end

   // error level per group; lowest group index has priority
   always_comb begin
      lvl = LVL_FULL;
      if (err_r[G_NO_CURRENT]) begin
         lvl = LVL_0V66;
      end else if (err_r[G_NO_VOLTAGE]) begin
         lvl = LVL_1V33;
      end else if (err_r[G_NO_BOTH]) begin
         lvl = LVL_2V00;
      end else if (err_r[G_TEMP_JUMP]) begin
         lvl = LVL_2V66;
      end else if (err_r[G_NET_FREQ]) begin
         lvl = LVL_3V33;
      end else if (err_r[G_HEAT_TIME]) begin
         lvl = LVL_4V00;
      end else if (err_r[G_INTERNAL]) begin
         lvl = LVL_4V66;
      end else if (err_r[G_ZERO_SIGNAL]) begin
         lvl = LVL_5V33;
      end else if (err_r[G_ZERO_TEMP]) begin
         lvl = LVL_6V00;
      end else if (err_r[G_CFG_CURRENT]) begin
         lvl = LVL_6V66;
      end else if (err_r[G_CFG_VOLTAGE]) begin
         lvl = LVL_7V33;
      end else if (err_r[G_CFG_BOTH]) begin
         lvl = LVL_8V00;
      end else if (err_r[G_CFG_EXT]) begin
         lvl = LVL_8V66;
      end
   end

   // registered outputs; all blinking follows the shared divider phases
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         alarm_led    <= 1'b0;
         alarm_out    <= 1'b0;
         actual_out   <= '0;
         alarm_active <= 1'b0;
      end else if (ce) begin
         alarm_active <= (cls != AES_CLS_NONE);
         case (cls)
            AES_CLS_FAULT: begin
               alarm_led  <= 1'b1;
               alarm_out  <= ~alarm_pol_inv;
               actual_out <= lvl;
            end
            AES_CLS_ZERO, AES_CLS_CFG: begin
               if (latched_start_r) begin
                  alarm_led  <= 1'b1;
                  alarm_out  <= ~alarm_pol_inv;
                  actual_out <= lvl;
               end else begin
                  // fast for zeroing, slow for configuration
                  alarm_led  <= (cls == AES_CLS_ZERO) ? fast_ph : slow_ph;
                  alarm_out  <= alarm_pol_inv;
                  actual_out <= slow_ph ? LVL_FULL : lvl;
               end
            end
            AES_CLS_NONE: begin
               alarm_led  <= 1'b0;
               alarm_out  <= alarm_pol_inv;
               actual_out <= temp_level;
            end
            default: begin
               alarm_led  <= 1'b1;
               alarm_out  <= ~alarm_pol_inv;
               actual_out <= lvl;
            end
         endcase
      end
   end
endmodule // aes_alarm

// >>> aes_alarm_chk.sv
// checker: port-level assertions for the alarm block
`timescale 1ns/1ps
module aes_alarm_chk
   import aes_pkg::*;
#(
   parameter int unsigned HALF_CYC = FAST_HALF_CYC
) (
   input wire logic             clk,
   input wire logic             sys_rst,
   input wire logic             ce,
   input wire logic [GRP_N-1:0] err_in,
   input wire logic             start_in,
   input wire logic             reset_in,
   input wire logic             alarm_pol_inv,
   input wire logic [LVL_W-1:0] temp_level,
   input wire logic             alarm_led,
   input wire logic             alarm_out,
   input wire logic [LVL_W-1:0] actual_out,
   input wire logic             alarm_active
);
   // lowest set group wins, which also puts faults before warnings
   function automatic logic [LVL_W-1:0] exp_lvl(logic [GRP_N-1:0] e);
      logic [LVL_W-1:0] t [GRP_N] = '{LVL_0V66, LVL_1V33, LVL_2V00, LVL_2V66, LVL_3V33,
         LVL_4V00, LVL_4V66, LVL_5V33, LVL_6V00, LVL_6V66, LVL_7V33, LVL_8V00, LVL_8V66};
      exp_lvl = LVL_FULL;
      for (int i = GRP_N - 1; i >= 0; i--) if (e[i]) exp_lvl = t[i];
   endfunction
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // eight stable cycles cover the four-edge input latency
   sequence s_fault;
      (err_in[6:0] != 7'h00 && $stable(err_in) && !reset_in)[*8];
   endsequence
   sequence s_warn;
      (err_in[6:0] == 7'h00 && err_in[12:7] != 6'h00 && $stable(err_in) && !reset_in)[*8];
   endsequence
   quiet_out_a: assert property (!$past(sys_rst) && !alarm_active
      |-> actual_out == $past(temp_level) && alarm_out == $past(alarm_pol_inv) && !alarm_led)
      else $error("quiet outputs wrong");
   fault_led_a: assert property (s_fault
      |-> alarm_led && alarm_active && alarm_out == !$past(alarm_pol_inv))
      else $error("fault led or alarm wrong");
   fault_const_a: assert property (s_fault |=> $stable(actual_out))
      else $error("fault level moves");
   err_level_a: assert property ((err_in != 0 && $stable(err_in) && !reset_in)[*8]
      |-> actual_out == exp_lvl(err_in) || (err_in[6:0] == 0 && actual_out == LVL_FULL))
      else $error("error level wrong");
   start_hold_a: assert property (s_warn and start_in[*8]
      |-> alarm_led && alarm_out == !$past(alarm_pol_inv) && $stable(actual_out))
      else $error("start does not hold warning");
   shared_phase_a: assert property ((s_warn and (!start_in)[*8]) ##0 $changed(actual_out)
      |-> $changed(alarm_led)) else $error("blink phases differ");
   hold_clear_a: assert property (reset_in[*6] |-> $stable(alarm_active))
      else $error("alarm moved while clear held");
   clear_a: assert property ((reset_in && err_in == 0)[*4] ##1 (!reset_in && err_in == 0)[*6]
      |-> !alarm_active) else $error("clear not taken");
endmodule // aes_alarm_chk

bind aes_alarm aes_alarm_chk #(.HALF_CYC(HALF_CYC)) u_chk (.clk, .sys_rst, .ce, .err_in,
   .start_in, .reset_in, .alarm_pol_inv, .temp_level, .alarm_led, .alarm_out, .actual_out,
   .alarm_active);

// >>> aes_plc_model.sv
// partner: controller that watches the alarm LED and error level outputs and counts changes
`timescale 1ns/1ps
module aes_plc_model
   import aes_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             clr,
   input  wire logic             alarm_led,
   input  wire logic [LVL_W-1:0] actual_out,
   output logic [7:0]            led_edges,
   output logic [7:0]            lvl_edges
);
   logic             led_d_r;
   logic [LVL_W-1:0] act_d_r;
   // the controller only reads, so it never pushes back on the block
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         led_edges <= 8'h00;
         lvl_edges <= 8'h00;
      end else if (clr) begin
         led_edges <= 8'h00;
         lvl_edges <= 8'h00;
      end else begin
         led_edges <= led_edges + {7'h00, alarm_led != led_d_r};
         lvl_edges <= lvl_edges + {7'h00, actual_out != act_d_r};
      end
   end
   // previous samples for change detection
   always_ff @(posedge clk) begin
      led_d_r <= alarm_led;
      act_d_r <= actual_out;
   end
endmodule // aes_plc_model

// >>> aes_alarm_tb_top.sv
// testbench: alarm block with controller model
`timescale 1ns/1ps
module aes_alarm_tb_top
   import aes_pkg::*;
;
   localparam int unsigned HC = 4; // short half period keeps the run small
   logic             clk, sys_rst, ce, start_in, reset_in, alarm_pol_inv, clr;
   logic [GRP_N-1:0] err_in;
   logic [LVL_W-1:0] temp_level, actual_out;
   logic             alarm_led, alarm_out, alarm_active;
   logic [7:0]       led_edges, lvl_edges;
   int               error_cnt = 0;
   int               n_tests = 0;
   logic [LVL_W-1:0] lvl [GRP_N] = '{LVL_0V66, LVL_1V33, LVL_2V00, LVL_2V66, LVL_3V33,
      LVL_4V00, LVL_4V66, LVL_5V33, LVL_6V00, LVL_6V66, LVL_7V33, LVL_8V00, LVL_8V66};
   aes_alarm #(.HALF_CYC(HC)) dut (.clk, .sys_rst, .ce, .err_in, .start_in, .reset_in,
      .alarm_pol_inv, .temp_level, .alarm_led, .alarm_out, .actual_out, .alarm_active);
   aes_plc_model plc (.clk, .sys_rst, .clr, .alarm_led, .actual_out, .led_edges, .lvl_edges);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic set_in(input logic [GRP_N-1:0] e, input logic s, input logic r);
      @(posedge clk);
      err_in <= e;
      start_in <= s;
      reset_in <= r;
   endtask
   // errors go away first, so the release finds nothing to reload
   task automatic t_clear();
      set_in(13'h0000, 1'b0, 1'b1);
      cyc(8);
      chk(alarm_active, 1'b1);
      set_in(13'h0000, 1'b0, 1'b0);
      cyc(8);
      chk(alarm_active, 1'b0);
   endtask
   task automatic t_fault(input int g);
      set_in(13'h0001 << g, 1'b0, 1'b0);
      cyc(8);
      chk(actual_out, lvl[g]);
      chk({alarm_led, alarm_out}, {1'b1, ~alarm_pol_inv});
      t_clear();
   endtask
   task automatic t_warn(input int g, input logic [7:0] n_led);
      set_in(13'h0001 << g, 1'b0, 1'b0);
      cyc(40);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      cyc(32 * HC);
      chk(led_edges, n_led);
      chk(lvl_edges, 8'h08);
      chk(alarm_out, alarm_pol_inv);
      set_in(13'h0001 << g, 1'b1, 1'b0);
      cyc(6);
      chk({alarm_led, alarm_out, actual_out}, {1'b1, ~alarm_pol_inv, lvl[g]});
      t_clear();
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      sys_rst = 1'b1;
      ce = 1'b1;
      err_in = '0;
      start_in = 1'b0;
      reset_in = 1'b0;
      alarm_pol_inv = 1'b0;
      clr = 1'b0;
      temp_level = 14'h0BB8;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      cyc(4);
      chk({alarm_led, alarm_out, actual_out}, {2'b00, 14'h0BB8});
      for (int g = 0; g < 7; g++) t_fault(g);
      for (int g = 7; g < 13; g++) t_warn(g, (g < 9) ? 8'h20 : 8'h08);
      @(posedge clk);
      alarm_pol_inv <= 1'b1;
      cyc(2);
      chk(alarm_out, 1'b1);
      t_fault(5);
      t_warn(8, 8'h20);
      t_warn(11, 8'h08);
      // a power cycle drops a latched fault
      set_in(13'h0040, 1'b0, 1'b0);
      cyc(8);
      sys_rst <= 1'b1;
      set_in(13'h0000, 1'b0, 1'b0);
      sys_rst <= 1'b0;
      cyc(6);
      chk(alarm_active, 1'b0);
      finish_test();
   end
endmodule // aes_alarm_tb_top
